// ==== rtl/mlic_pkg.sv ====
// Constants, field layout and vector table of the multilevel interrupt controller
package mlic_pkg;

    // ------------------------------------------------------------
    // Vector addresses (program word addresses)
    // ------------------------------------------------------------
    localparam int          MLIC_VEC_W                = 16;
    localparam logic [15:0] MLIC_RESET_VECTOR         = 16'h0000;
    localparam logic [15:0] MLIC_OSC_FAIL_VECTOR      = 16'h0002;
    localparam logic [15:0] MLIC_FIRST_PORT_IRQ_BASE  = 16'h0004;
    localparam logic [15:0] MLIC_FIRST_TIMER_IRQ_BASE = 16'h001C;
    localparam logic [15:0] MLIC_FIRST_SPI_IRQ_VECTOR = 16'h0030;
    localparam int          MLIC_NUM_BASES            = 24;
    localparam logic [15:0] MLIC_BASE_TABLE [MLIC_NUM_BASES] = '{
        MLIC_FIRST_PORT_IRQ_BASE, 16'h0008, 16'h0014, 16'h0018, MLIC_FIRST_TIMER_IRQ_BASE, 16'h0028,
        MLIC_FIRST_SPI_IRQ_VECTOR, 16'h0032, 16'h0040, 16'h0044, 16'h0056, 16'h005A,
        16'h005E, 16'h0074, 16'h0080, 16'h0084, 16'h0088, 16'h008E,
        16'h009A, 16'h00AE, 16'h00B0, 16'h00B6, 16'h00D0, 16'h00D8
    };

    // ------------------------------------------------------------
    // Register map (byte offsets)
    // ------------------------------------------------------------
    localparam int          MLIC_ADDR_W     = 12;
    localparam logic [11:0] MLIC_CTRL_OFS   = 12'h000;
    localparam logic [11:0] MLIC_STATUS_OFS = 12'h004;
    localparam logic [11:0] MLIC_LAST_OFS   = 12'h008;
    localparam logic [11:0] MLIC_SRC_OFS    = 12'h040;

    // Control register fields
    localparam int          MLIC_CTRL_RR_BIT    = 0;
    localparam int          MLIC_CTRL_BOOT_BIT  = 1;
    localparam int          MLIC_CTRL_LVLEN_LSB = 2;
    localparam int          MLIC_CTRL_W         = 5;
    localparam logic [4:0]  MLIC_CTRL_RST       = 5'h00;

    // Per-source configuration fields
    localparam int          MLIC_SRC_LVL_LSB  = 0;
    localparam int          MLIC_SRC_BASE_LSB = 2;
    localparam int          MLIC_SRC_BASE_W   = 5;
    localparam int          MLIC_SRC_OFF_LSB  = 8;
    localparam int          MLIC_SRC_OFF_W    = 8;
    localparam int          MLIC_SRC_W        = 16;
    localparam logic [15:0] MLIC_SRC_RST      = 16'h0000;

    // Status register fields
    localparam int          MLIC_STAT_LVL_LSB = 4;
    localparam int          MLIC_STAT_REQ_BIT = 7;

    // ------------------------------------------------------------
    // Levels and ranks
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MLIC_LVL_OFF  = 2'b00,
        MLIC_LVL_LOW  = 2'b01,
        MLIC_LVL_MED  = 2'b10,
        MLIC_LVL_HIGH = 2'b11
    } mlic_level_type;

    localparam logic [2:0] MLIC_RANK_NONE = 3'h0;
    localparam logic [2:0] MLIC_RANK_LOW  = 3'h1;
    localparam logic [2:0] MLIC_RANK_MED  = 3'h2;
    localparam logic [2:0] MLIC_RANK_HIGH = 3'h3;
    localparam logic [2:0] MLIC_RANK_NMI  = 3'h4;

    // Arbitration key: inverted level, round-robin demotion, vector
    localparam int MLIC_KEY_W = 19;

endpackage

// ==== rtl/mlic_prio_pick.sv ====
// Smallest-key picker over all eligible interrupt sources
module mlic_prio_pick #(
    parameter int NUM   = 16,
    parameter int KEY_W = 19,
    parameter int IDX_W = 4
) (
    input  wire logic [NUM-1:0]            reqValid,
    input  wire logic [NUM-1:0][KEY_W-1:0] reqKey,
    output wire logic                      anyValid,
    output wire logic [IDX_W-1:0]          bestIdx,
    output wire logic [KEY_W-1:0]          bestKey
);

    wire [NUM:0]            chainValid;
    wire [NUM:0][KEY_W-1:0] chainKey;
    wire [NUM:0][IDX_W-1:0] chainIdx;

    assign chainValid[0] = 1'b0;
    assign chainKey[0]   = '1;
    assign chainIdx[0]   = '0;

    genvar g;
    generate
        for (g = 0; g < NUM; g++) begin : gen_stage
            // Strict compare: on equal keys the lower index keeps the grant
            wire take = reqValid[g] && (!chainValid[g] || reqKey[g] < chainKey[g]);
            assign chainValid[g+1] = chainValid[g] | reqValid[g];
            assign chainKey[g+1]   = take ? reqKey[g] : chainKey[g];
            assign chainIdx[g+1]   = take ? IDX_W'(g) : chainIdx[g];
        end
    endgenerate

    assign anyValid = chainValid[NUM];
    assign bestKey  = chainKey[NUM];
    assign bestIdx  = chainIdx[NUM];

endmodule

// ==== rtl/mlic_multilevel_irq_ctrl.sv ====
// Multilevel interrupt controller with APB configuration and CPU vector steering
// Functional notes
// - Every source has its own configuration word and its own vector.
// - A source configured with a level raises a request while its request input is high.
// - Each source is assigned low, medium or high level, each level gated by its own enable.
// - A medium request is offered to the CPU while only low-level handlers are in service.
// - A high request is offered while medium or low handlers are in service.
// - Among requests of the same level the smallest vector is granted first.
// - An optional round-robin scheme rotates service among low-level sources.
// - The oscillator-failure interrupt is non-maskable and ranks above all levels.
// - On CPU acknowledge the program counter load carries the granted vector.
// - A vector is the peripheral base address plus the interrupt offset.
// - All vectors are program word addresses.
// - The vector table sits in the application or boot area by a control bit.
// - The reset entry is word 0x000 and the oscillator-failure vector is word 0x002.
// - Peripheral bases are fixed word addresses from a constant table.
module mlic_multilevel_irq_ctrl #(
    parameter int          NUM_SRC   = 16,
    parameter logic [15:0] BOOT_BASE = 16'h8000
) (
    input  wire logic                   ref_clk,
    input  wire logic                   nrst,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic [NUM_SRC-1:0]     srcReq,
    input  wire logic                   oscFailReq,
    output logic                        irqReq,
    output logic      [2:0]             irqLevel,
    output logic      [15:0]            irqVector,
    input  wire logic                   cpuAck,
    input  wire logic                   cpuReti,
    output logic                        pcLoad,
    output logic      [15:0]            pcVector
);

    localparam int IDX_W = (NUM_SRC > 1) ? $clog2(NUM_SRC) : 1;
    localparam int KEY_W = mlic_pkg::MLIC_KEY_W;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    logic                        pready_ff;
    logic [31:0]                 prdata_ff;
    logic                        pslverr_ff;
    logic [mlic_pkg::MLIC_CTRL_W-1:0] ctrl_ff;
    logic [mlic_pkg::MLIC_SRC_W-1:0]  srcCfg_ff [NUM_SRC];
    logic [3:0]                  inService_ff;
    logic                        irqReq_ff;
    logic [2:0]                  irqLevel_ff;
    logic [15:0]                 irqVector_ff;
    logic [15:0]                 grantVec_ff;
    logic [15:0]                 rrLastVec_ff;
    logic [15:0]                 lastVec_ff;
    logic                        pcLoad_ff;
    logic [15:0]                 pcVector_ff;

    wire        apbAccess = psel & penable;
    wire        apbDone   = apbAccess & pready_ff;
    wire        apbWrite  = apbDone & pwrite;
    wire        apbFirst  = apbAccess & ~pready_ff;
    wire [11:0] srcOff    = paddr - mlic_pkg::MLIC_SRC_OFS;
    wire        hitCtrl   = paddr == mlic_pkg::MLIC_CTRL_OFS;
    wire        hitStatus = paddr == mlic_pkg::MLIC_STATUS_OFS;
    wire        hitLast   = paddr == mlic_pkg::MLIC_LAST_OFS;
    wire        hitSrc    = (paddr >= mlic_pkg::MLIC_SRC_OFS) && (paddr[1:0] == 2'h0) &&
                            (int'(srcOff[11:2]) < NUM_SRC);
    wire        mapped    = hitCtrl | hitStatus | hitLast | hitSrc;
    wire [IDX_W-1:0] srcIdx = srcOff[IDX_W+1:2];

    wire        rrEnable  = ctrl_ff[mlic_pkg::MLIC_CTRL_RR_BIT];
    wire        bootSel   = ctrl_ff[mlic_pkg::MLIC_CTRL_BOOT_BIT];
    wire [2:0]  lvlEnable = ctrl_ff[mlic_pkg::MLIC_CTRL_LVLEN_LSB +: 3];

    wire [31:0] statusWord = {24'h000000, irqReq_ff, irqLevel_ff, inService_ff};
    wire [31:0] readMux    = hitCtrl   ? {27'h0000000, ctrl_ff} :
                             hitStatus ? statusWord :
                             hitLast   ? {16'h0000, lastVec_ff} :
                             hitSrc    ? {16'h0000, srcCfg_ff[srcIdx]} : 32'h00000000;

    // One wait state so read data and error come straight from flops
    wire        nxt_pready  = apbFirst;
    wire [31:0] nxt_prdata  = apbFirst ? (pwrite ? 32'h00000000 : readMux) : 32'h00000000;
    wire        nxt_pslverr = apbFirst & ~mapped;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= nxt_pready;
            prdata_ff  <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff <= mlic_pkg::MLIC_CTRL_RST;
        end else if (apbWrite && hitCtrl) begin
            ctrl_ff <= pwdata[mlic_pkg::MLIC_CTRL_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Per-source configuration and arbitration keys
    // ------------------------------------------------------------
    wire [NUM_SRC-1:0]            srcElig;
    wire [NUM_SRC-1:0]            srcIsMed;
    wire [NUM_SRC-1:0]            srcIsHigh;
    wire [NUM_SRC-1:0][15:0]      srcVec;
    wire [NUM_SRC-1:0][KEY_W-1:0] srcKey;
    wire [2:0]                    topRank;

    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : gen_src
            wire [1:0] lvl   = srcCfg_ff[g][mlic_pkg::MLIC_SRC_LVL_LSB +: 2];
            wire [4:0] bsel  = srcCfg_ff[g][mlic_pkg::MLIC_SRC_BASE_LSB +: mlic_pkg::MLIC_SRC_BASE_W];
            wire [7:0] off   = srcCfg_ff[g][mlic_pkg::MLIC_SRC_OFF_LSB +: mlic_pkg::MLIC_SRC_OFF_W];
            wire [15:0] base = (int'(bsel) < mlic_pkg::MLIC_NUM_BASES) ?
                               mlic_pkg::MLIC_BASE_TABLE[bsel] : 16'h0000;
            wire       isOn  = lvl != mlic_pkg::MLIC_LVL_OFF;
            wire       lvlOk = isOn && lvlEnable[lvl - 2'h1];
            wire       rrDemote = rrEnable && (lvl == mlic_pkg::MLIC_LVL_LOW) &&
                                  (srcVec[g] <= rrLastVec_ff);

            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    srcCfg_ff[g] <= mlic_pkg::MLIC_SRC_RST;
                end else if (apbWrite && hitSrc && srcIdx == IDX_W'(g)) begin
                    srcCfg_ff[g] <= pwdata[mlic_pkg::MLIC_SRC_W-1:0];
                end
            end

            // Word address: base and offset add without scaling
            assign srcVec[g]    = base + {8'h00, off};
            // Only a level above the running handler may request
            assign srcElig[g]   = srcReq[g] && lvlOk && ({1'b0, lvl} > topRank);
            assign srcIsMed[g]  = srcElig[g] && (lvl == mlic_pkg::MLIC_LVL_MED);
            assign srcIsHigh[g] = srcElig[g] && (lvl == mlic_pkg::MLIC_LVL_HIGH);
            // Higher level first, then round-robin group, then vector
            assign srcKey[g]    = {~lvl, rrDemote, srcVec[g]};
        end
    endgenerate

    // ------------------------------------------------------------
    // Grant selection
    // ------------------------------------------------------------
    wire                 anyValid;
    wire [IDX_W-1:0]     bestIdx;
    wire [KEY_W-1:0]     bestKey;

    mlic_prio_pick #(
        .NUM   (NUM_SRC),
        .KEY_W (KEY_W),
        .IDX_W (IDX_W)
    ) u_pick (
        .reqValid (srcElig),
        .reqKey   (srcKey),
        .anyValid (anyValid),
        .bestIdx  (bestIdx),
        .bestKey  (bestKey)
    );


    assign topRank = inService_ff[3] ? mlic_pkg::MLIC_RANK_NMI  :
                     inService_ff[2] ? mlic_pkg::MLIC_RANK_HIGH :
                     inService_ff[1] ? mlic_pkg::MLIC_RANK_MED  :
                     inService_ff[0] ? mlic_pkg::MLIC_RANK_LOW  : mlic_pkg::MLIC_RANK_NONE;
    wire [3:0] topMask = inService_ff[3] ? 4'h8 :
                         inService_ff[2] ? 4'h4 :
                         inService_ff[1] ? 4'h2 :
                         inService_ff[0] ? 4'h1 : 4'h0;

    // Non-maskable: ignores level enables, blocked only by its own handler
    wire        nmiElig   = oscFailReq && !inService_ff[3];
    wire        candValid = nmiElig | anyValid;
    wire [2:0]  candRank  = nmiElig ? mlic_pkg::MLIC_RANK_NMI : {1'b0, ~bestKey[KEY_W-1 -: 2]};
    wire [15:0] candVec   = nmiElig ? mlic_pkg::MLIC_OSC_FAIL_VECTOR : bestKey[15:0];
    wire [15:0] candPc    = bootSel ? (BOOT_BASE + candVec) : candVec;
    wire        anyMed    = |srcIsMed;
    wire        anyHigh   = |srcIsHigh;

    // ------------------------------------------------------------
    // CPU handshake and in-service tracking
    // ------------------------------------------------------------
    wire        ackTaken   = cpuAck & irqReq_ff;
    wire [3:0]  ackMask    = ackTaken ? (4'h1 << (irqLevel_ff - 3'h1)) : 4'h0;
    wire [3:0]  retiMask   = cpuReti ? topMask : 4'h0;
    // Return clears first, so an ack in the same cycle still sets its bit
    wire [3:0]  nxt_inService = (inService_ff & ~retiMask) | ackMask;
    // Request is withheld the cycle after a service change; it was ranked on stale state
    wire        nxt_irqReq    = candValid && !cpuAck && !cpuReti;
    wire        nxt_pcLoad    = ackTaken;
    wire [15:0] nxt_pcVector  = ackTaken ? irqVector_ff : pcVector_ff;
    wire [15:0] nxt_rrLastVec = (ackTaken && irqLevel_ff == mlic_pkg::MLIC_RANK_LOW) ?
                                grantVec_ff : rrLastVec_ff;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            inService_ff <= 4'h0;
            irqReq_ff    <= 1'b0;
            irqLevel_ff  <= mlic_pkg::MLIC_RANK_NONE;
            irqVector_ff <= mlic_pkg::MLIC_RESET_VECTOR;
            grantVec_ff  <= mlic_pkg::MLIC_RESET_VECTOR;
        end else begin
            inService_ff <= nxt_inService;
            irqReq_ff    <= nxt_irqReq;
            irqLevel_ff  <= candRank;
            irqVector_ff <= candPc;
            grantVec_ff  <= candVec;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pcLoad_ff    <= 1'b0;
            pcVector_ff  <= mlic_pkg::MLIC_RESET_VECTOR;
            rrLastVec_ff <= 16'h0000;
            lastVec_ff   <= mlic_pkg::MLIC_RESET_VECTOR;
        end else begin
            pcLoad_ff    <= nxt_pcLoad;
            pcVector_ff  <= nxt_pcVector;
            rrLastVec_ff <= nxt_rrLastVec;
            lastVec_ff   <= nxt_pcVector;
        end
    end

    assign prdata    = prdata_ff;
    assign pready    = pready_ff;
    assign pslverr   = pslverr_ff;
    assign irqReq    = irqReq_ff;
    assign irqLevel  = irqLevel_ff;
    assign irqVector = irqVector_ff;
    assign pcLoad    = pcLoad_ff;
    assign pcVector  = pcVector_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence ackSeq;
        irqReq_ff && cpuAck;
    endsequence

    sequence quietSeq;
        !cpuAck && !cpuReti;
    endsequence

    ack_loads_pc_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        ackSeq |=> pcLoad_ff && (pcVector_ff == $past(irqVector_ff)) ##1 !pcLoad_ff)
        else $error("acknowledge did not load the granted vector");

    req_above_service_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        irqReq_ff |-> (irqLevel_ff > topRank))
        else $error("offered request does not outrank the running handler");

    med_preempt_low_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        ((inService_ff == 4'h1) && anyMed && !anyHigh && !nmiElig) and quietSeq
        |=> irqReq_ff && (irqLevel_ff == mlic_pkg::MLIC_RANK_MED))
        else $error("medium request did not preempt low handler");

    high_preempt_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        ((inService_ff[3:2] == 2'h0) && (inService_ff[1:0] != 2'h0) && anyHigh && !nmiElig) and quietSeq
        |=> irqReq_ff && (irqLevel_ff == mlic_pkg::MLIC_RANK_HIGH))
        else $error("high request did not preempt lower handler");

    nmi_vector_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        nmiElig and quietSeq |=> irqReq_ff && (irqLevel_ff == mlic_pkg::MLIC_RANK_NMI) &&
        (irqVector_ff == ($past(bootSel) ? BOOT_BASE + mlic_pkg::MLIC_OSC_FAIL_VECTOR :
                                            mlic_pkg::MLIC_OSC_FAIL_VECTOR)))
        else $error("oscillator failure not offered at its vector");

    reti_clears_top_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        cpuReti && !cpuAck && (inService_ff != 4'h0)
        |=> (inService_ff == ($past(inService_ff) & ~$past(topMask))))
        else $error("return did not clear the most recent level");

    rr_last_demoted_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        ackSeq and (irqLevel_ff == mlic_pkg::MLIC_RANK_LOW) |=> (rrLastVec_ff == $past(grantVec_ff)))
        else $error("round-robin pointer not moved to acknowledged vector");

    level_enabled_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        // A level disabled in this very cycle may still show its request once
        irqReq_ff && (irqLevel_ff != mlic_pkg::MLIC_RANK_NMI) && $stable(lvlEnable)
        |-> lvlEnable[irqLevel_ff[1:0] - 2'h1])
        else $error("request offered for a disabled level");

    apb_one_wait_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        apbFirst |=> pready_ff ##1 !pready_ff)
        else $error("APB answer not after exactly one wait state");

    pick_winner_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        anyValid |-> srcElig[bestIdx] && (srcKey[bestIdx] == bestKey))
        else $error("picked source is not an eligible winner");

endmodule

// ==== bench/mlic_cpu_model.sv ====
// CPU side model: acknowledges offered interrupts and issues handler returns
module mlic_cpu_model (
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic       irqReq,
    input  wire logic [3:0] ackWait,
    input  wire logic       retiGo,
    output logic            cpuAck,
    output logic            cpuReti
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] waitCnt;
    // Slow CPU: ackWait+1 cycles of offer before the single-cycle ack
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            waitCnt <= 4'h0;
            cpuAck  <= 1'b0;
            cpuReti <= 1'b0;
        end else begin
            waitCnt <= !irqReq ? 4'h0 : (waitCnt < ackWait) ? waitCnt + 4'h1 : waitCnt;
            cpuAck  <= irqReq && (waitCnt >= ackWait) && !cpuAck;
            cpuReti <= retiGo && !cpuReti;
        end
    end
endmodule

// ==== bench/mlic_multilevel_irq_ctrl_bench.sv ====
// Self-checking bench for the multilevel interrupt controller
module mlic_multilevel_irq_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {int idx; logic [1:0] lvl; int base; logic [7:0] off; logic boot; logic [15:0] vec;} mlic_row_type;
    mlic_row_type rows [4] = '{'{0, 2'h1, 0, 8'h00, 1'b0, 16'h0004}, '{3, 2'h2, 4, 8'h05, 1'b0, 16'h0021},
                               '{7, 2'h3, 6, 8'h00, 1'b1, 16'h8030}, '{15, 2'h1, 23, 8'h10, 1'b1, 16'h80E8}};
    logic        ref_clk, nrst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] srcReq, irqVector, pcVector;
    logic        oscFailReq, irqReq, cpuAck, cpuReti, pcLoad, retiGo;
    logic [2:0]  irqLevel;
    logic [3:0]  ackWait;
    int          failures, checkCount, cycles;

    mlic_multilevel_irq_ctrl #(.NUM_SRC(16), .BOOT_BASE(16'h8000)) uut (
        .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .srcReq(srcReq), .oscFailReq(oscFailReq), .irqReq(irqReq), .irqLevel(irqLevel),
        .irqVector(irqVector), .cpuAck(cpuAck), .cpuReti(cpuReti), .pcLoad(pcLoad), .pcVector(pcVector));
    mlic_cpu_model cpu (.ref_clk(ref_clk), .nrst(nrst), .irqReq(irqReq), .ackWait(ackWait),
        .retiGo(retiGo), .cpuAck(cpuAck), .cpuReti(cpuReti));

    // --------
    // Clock, watchdog and reporting
    // --------
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checkCount, failures);
        if (failures == 0 && checkCount > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chkVec(input logic [15:0] got, input logic [15:0] exp, input string m);
        checkCount++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp, input string m);
        checkCount++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // --------
    // APB master and CPU helpers
    // --------
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        @(posedge ref_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rdChk(input logic [11:0] a, input logic [31:0] exp, input logic expErr);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chkWord(q, exp, "read data");
        chkWord({31'h0, e}, {31'h0, expErr}, "slave error");
    endtask
    task automatic src(input int i, input logic [1:0] l, input int b, input logic [7:0] o);
        wr(mlic_pkg::MLIC_SRC_OFS + 12'(4 * i), {16'h0, o, 1'b0, 5'(b), l});
    endtask
    // Waits for the PC load and checks vector and offered level
    task automatic take(input logic [15:0] v, input logic [2:0] l);
        logic [2:0]  lvl;
        logic [15:0] ivec;
        lvl = 3'h0;
        ivec = 16'h0000;
        do begin
            @(posedge ref_clk);
            if (irqReq === 1'b1) begin
                lvl = irqLevel;
                ivec = irqVector;
            end
        end while (pcLoad !== 1'b1);
        chkVec(pcVector, v, "pc vector");
        chkVec(ivec, v, "offered vector");
        chkWord({29'h0, lvl}, {29'h0, l}, "level");
    endtask
    task automatic ret();
        @(posedge ref_clk);
        retiGo <= 1'b1;
        @(posedge ref_clk);
        retiGo <= 1'b0;
        @(posedge ref_clk);
    endtask

    // --------
    // Main sequence
    // --------
    initial begin
        {ref_clk, nrst, psel, penable, pwrite, oscFailReq, retiGo} = '0;
        {paddr, pwdata, srcReq, ackWait} = '0;
        {failures, checkCount, cycles} = '0;
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        chkVec(pcVector, mlic_pkg::MLIC_RESET_VECTOR, "reset entry");
        rdChk(mlic_pkg::MLIC_CTRL_OFS, 32'h0, 1'b0);
        rdChk(mlic_pkg::MLIC_STATUS_OFS, 32'h0, 1'b0);
        rdChk(12'hFFC, 32'h0, 1'b1);
        foreach (rows[k]) begin
            wr(mlic_pkg::MLIC_CTRL_OFS, {27'h0, 3'b111, rows[k].boot, 1'b0});
            src(rows[k].idx, rows[k].lvl, rows[k].base, rows[k].off);
            srcReq[rows[k].idx] <= 1'b1;
            take(rows[k].vec, {1'b0, rows[k].lvl});
            srcReq[rows[k].idx] <= 1'b0;
            ret();
            src(rows[k].idx, 2'h0, 0, 8'h00);
        end
        // Oscillator failure must get through with every level disabled
        wr(mlic_pkg::MLIC_CTRL_OFS, 32'h0);
        oscFailReq <= 1'b1;
        take(16'h0002, 3'h4);
        oscFailReq <= 1'b0;
        ret();
        // Nesting with a slow CPU
        ackWait <= 4'h3;
        wr(mlic_pkg::MLIC_CTRL_OFS, 32'h1C);
        src(2, 2'h1, 1, 8'h00);
        src(3, 2'h2, 4, 8'h00);
        src(7, 2'h3, 6, 8'h00);
        srcReq[2] <= 1'b1;
        take(16'h0008, 3'h1);
        srcReq    <= 16'h0008;
        take(16'h001C, 3'h2);
        srcReq    <= 16'h0080;
        take(16'h0030, 3'h3);
        srcReq    <= 16'h0008;
        rdChk(mlic_pkg::MLIC_STATUS_OFS, 32'h7, 1'b0);
        ret();
        repeat (5) @(posedge ref_clk);
        chkWord({31'h0, irqReq}, 32'h0, "equal level nested");
        ret();
        take(16'h001C, 3'h2);
        srcReq <= 16'h0;
        repeat (3) ret();
        rdChk(mlic_pkg::MLIC_STATUS_OFS, 32'h0, 1'b0);
        // Two low sources, fixed order then round robin
        ackWait <= 4'h0;
        src(1, 2'h1, 2, 8'h00);
        src(3, 2'h0, 0, 8'h00);
        srcReq <= 16'h0006;
        take(16'h0008, 3'h1);
        ret();
        take(16'h0008, 3'h1);
        srcReq <= 16'h0;
        ret();
        wr(mlic_pkg::MLIC_CTRL_OFS, 32'h1D);
        srcReq <= 16'h0006;
        take(16'h0014, 3'h1);
        ret();
        take(16'h0008, 3'h1);
        srcReq <= 16'h0004;
        ret();
        // Reset in the middle of a handler
        take(16'h0008, 3'h1);
        rdChk(mlic_pkg::MLIC_LAST_OFS, 32'h8, 1'b0);
        srcReq <= 16'h0;
        nrst   <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        chkVec(pcVector, mlic_pkg::MLIC_RESET_VECTOR, "reset entry again");
        rdChk(mlic_pkg::MLIC_STATUS_OFS, 32'h0, 1'b0);
        rdChk(mlic_pkg::MLIC_CTRL_OFS, 32'h0, 1'b0);
        tally_and_finish();
    end
endmodule
